// >>> verilog/pcap_defines.svh
// What this block does
// - Each array path selects direct or stored input
// - Input storage is flip-flop or latch
// - Flip-flop form captures on rising clock edge
// - Latch form transparent while clock high
// - Optional clock inversion for the input element
// - Latch and flip-flop combined within one cell
// - Input and output storage share one enable
// - Enable acts on input, output, or both
// - Shared enable is active high, never inverted
// - Enabled flip-flop loads pad on active edge
// - Global set/reset loads initial value; reset clears storage to zero
// - Unused enable behaves as permanently high
//
// Constants of the pad input capture block: register map, fields, reset values.
// Assumes inclusion by every design file that decodes the control word.
`ifndef PCAP_DEFINES_SVH
`define PCAP_DEFINES_SVH

// ==========================================================================
// Register map
`define PCAP_CTRL_OFS 32'h0000_0000
`define PCAP_STATUS_OFS 32'h0000_0004
`define PCAP_WORD_MASK 32'hFFFF_FFFC
`define PCAP_CTRL_RESET 32'h0000_0060
`define PCAP_CTRL_MASK 32'h0000_03FF

// ==========================================================================
// Control fields
`define PCAP_PATH_A_BIT 0
`define PCAP_PATH_B_BIT 1
`define PCAP_MODE_BIT 2
`define PCAP_IN_INV_BIT 3
`define PCAP_INIT_BIT 4
`define PCAP_CE_TGT_MSB 6
`define PCAP_CE_TGT_LSB 5
`define PCAP_CE_USED_BIT 7
`define PCAP_FC_EN_BIT 8
`define PCAP_OUT_INV_BIT 9

// ==========================================================================
// Status fields
`define PCAP_ST_PAD_BIT 0
`define PCAP_ST_IN_Q_BIT 1
`define PCAP_ST_FC_Q_BIT 2
`define PCAP_ST_OUT_Q_BIT 3
`define PCAP_ST_CE_IN_BIT 4
`define PCAP_ST_CE_OUT_BIT 5

// ==========================================================================
// Bus answers
`define PCAP_RESP_OKAY 2'h0
`define PCAP_RESP_SLVERR 2'h2
`define PCAP_DATA_ZERO 32'h0000_0000

`endif

// >>> verilog/pcap_pkg.sv
// Types of the pad input capture block.
// Assumes pcap_defines.svh supplies the numeric constants.
package pcap_pkg;

   // =======================================================================
   // Storage element form
   typedef enum logic {
      PCAP_MODE_FLOP = 1'b0,
      PCAP_MODE_LATCH = 1'b1
   } pcap_mode_t;

   // Where the shared enable acts, Gray ordered
   typedef enum logic [1:0] {
      PCAP_CE_NONE = 2'b00,
      PCAP_CE_IN = 2'b01,
      PCAP_CE_BOTH = 2'b11,
      PCAP_CE_OUT = 2'b10
   } pcap_ce_tgt_t;

   // =======================================================================
   // AXI4-Lite carriers
   typedef struct packed {
      logic [31:0] awaddr;
      logic awvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic wvalid;
      logic bready;
      logic [31:0] araddr;
      logic arvalid;
      logic rready;
   } pcap_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic [1:0] bresp;
      logic bvalid;
      logic arready;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
   } pcap_axi_rsp_t;

endpackage

// >>> verilog/pcap_clk_edge.sv
// Effective level and rising edge of a sampled storage clock.
// Assumes the clock pin is synchronous to the system clock.
`timescale 1ns/1ps
module pcap_clk_edge (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic lvl_i,
   input wire logic inv_i,
   output logic eff_o,
   output logic rise_o
);
   logic prev_reg;

   // =======================================================================
   // Inversion turns rising into falling edge, high into low transparency
   assign eff_o = lvl_i ^ inv_i;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= eff_o;
      end
   end

   // Toggling inversion can fake one edge; change it only while global set/reset is high
   assign rise_o = eff_o & ~prev_reg;
endmodule // pcap_clk_edge

// >>> verilog/pcap_store_elem.sv
// One configurable storage element: rising-edge flip-flop or high latch.
// Assumes level and edge come from pcap_clk_edge in the same clock domain.
`timescale 1ns/1ps
module pcap_store_elem (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic gsr_i,
   input wire logic init_i,
   input wire pcap_pkg::pcap_mode_t mode_i,
   input wire logic lvl_i,
   input wire logic rise_i,
   input wire logic ce_i,
   input wire logic d_i,
   output logic q_o
);
   import pcap_pkg::*;

   logic q_reg;

   // =======================================================================
   // Global set/reset outranks the clock; reset outranks both and clears
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q_reg <= 1'b0;
      end else if (gsr_i) begin
         q_reg <= init_i;
      end else if (ce_i) begin
         unique case (mode_i)
            PCAP_MODE_FLOP: begin
               if (rise_i) begin
                  q_reg <= d_i;
               end
            end
            PCAP_MODE_LATCH: begin
               if (lvl_i) begin
                  q_reg <= d_i;
               end
            end
         endcase
      end
   end

   assign q_o = q_reg;
endmodule // pcap_store_elem

// >>> verilog/pcap_top.sv
// Pad input capture: two array paths, input/fast-capture/output storage, AXI4-Lite.
// Assumes pad, storage clocks and enable are synchronous to SYS_CLK_I.
`timescale 1ns/1ps
`include "pcap_defines.svh"
module pcap_top (
   input wire logic SYS_CLK_I,
   input wire logic RESET_I,
   input wire logic PAD_I,
   input wire logic IN_CLK_I,
   input wire logic OUT_CLK_I,
   input wire logic CLK_EN_I,
   input wire logic GLOBAL_SET_RESET_I,
   input wire logic OUT_D_I,
   input wire pcap_pkg::pcap_axi_req_t S_AXI_REQ_I,
   output pcap_pkg::pcap_axi_rsp_t S_AXI_RSP_O,
   output logic ARRAY_INPUT_PATH_A_O,
   output logic ARRAY_INPUT_PATH_B_O,
   output logic OUT_Q_O
);
   import pcap_pkg::*;

   // =======================================================================
   // Declarations
   logic [31:0] ctrl_reg;
   logic [31:0] ctrl_next;
   logic [31:0] status_word;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic aw_have_reg;
   logic w_have_reg;
   logic [31:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic wr_do;
   logic aw_have_next;
   logic w_have_next;
   logic bvalid_next;
   logic rvalid_next;
   logic [31:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_hit_ctrl;
   logic path_a_reg;
   logic path_b_reg;
   pcap_mode_t in_mode;
   pcap_ce_tgt_t ce_tgt;
   logic ce_pin;
   logic ce_in;
   logic ce_out;
   logic in_eff;
   logic in_rise;
   logic out_eff;
   logic out_rise;
   logic fc_q;
   logic in_q;
   logic out_q;
   logic in_d;
   logic init_val;

   // =======================================================================
   // Control decode
   assign in_mode = pcap_mode_t'(ctrl_reg[`PCAP_MODE_BIT]);
   assign ce_tgt = pcap_ce_tgt_t'(ctrl_reg[`PCAP_CE_TGT_MSB:`PCAP_CE_TGT_LSB]);
   assign init_val = ctrl_reg[`PCAP_INIT_BIT];

   // No inversion on the enable; an unused enable reads as high
   assign ce_pin = ctrl_reg[`PCAP_CE_USED_BIT] ? CLK_EN_I : 1'b1;

   // One enable pin, steered to either element or both
   always_comb begin
      ce_in = 1'b1;
      ce_out = 1'b1;
      unique case (ce_tgt)
         PCAP_CE_NONE: begin
            ce_in = 1'b1;
            ce_out = 1'b1;
         end
         PCAP_CE_IN: begin
            ce_in = ce_pin;
         end
         PCAP_CE_OUT: begin
            ce_out = ce_pin;
         end
         PCAP_CE_BOTH: begin
            ce_in = ce_pin;
            ce_out = ce_pin;
         end
      endcase
   end

   // =======================================================================
   // Storage clocks
   pcap_clk_edge u_in_edge (
      .clk_i(SYS_CLK_I),
      .rst_i(RESET_I),
      .lvl_i(IN_CLK_I),
      .inv_i(ctrl_reg[`PCAP_IN_INV_BIT]),
      .eff_o(in_eff),
      .rise_o(in_rise)
   );

   pcap_clk_edge u_out_edge (
      .clk_i(SYS_CLK_I),
      .rst_i(RESET_I),
      .lvl_i(OUT_CLK_I),
      .inv_i(ctrl_reg[`PCAP_OUT_INV_BIT]),
      .eff_o(out_eff),
      .rise_o(out_rise)
   );

   // =======================================================================
   // Storage elements
   // Fast-capture latch, transparent while the output clock is low
   pcap_store_elem u_fc_latch (
      .clk_i(SYS_CLK_I),
      .rst_i(RESET_I),
      .gsr_i(GLOBAL_SET_RESET_I),
      .init_i(init_val),
      .mode_i(PCAP_MODE_LATCH),
      .lvl_i(~out_eff),
      .rise_i(1'b0),
      .ce_i(1'b1),
      .d_i(PAD_I),
      .q_o(fc_q)
   );

   // Latch ahead of the input element makes the combined pair
   assign in_d = ctrl_reg[`PCAP_FC_EN_BIT] ? fc_q : PAD_I;

   pcap_store_elem u_in_store (
      .clk_i(SYS_CLK_I),
      .rst_i(RESET_I),
      .gsr_i(GLOBAL_SET_RESET_I),
      .init_i(init_val),
      .mode_i(in_mode),
      .lvl_i(in_eff),
      .rise_i(in_rise),
      .ce_i(ce_in),
      .d_i(in_d),
      .q_o(in_q)
   );

   pcap_store_elem u_out_store (
      .clk_i(SYS_CLK_I),
      .rst_i(RESET_I),
      .gsr_i(GLOBAL_SET_RESET_I),
      .init_i(init_val),
      .mode_i(PCAP_MODE_FLOP),
      .lvl_i(out_eff),
      .rise_i(out_rise),
      .ce_i(ce_out),
      .d_i(OUT_D_I),
      .q_o(out_q)
   );

   assign OUT_Q_O = out_q;

   // =======================================================================
   // Array paths; the direct path also costs one register stage
   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         path_a_reg <= 1'b0;
         path_b_reg <= 1'b0;
      end else begin
         path_a_reg <= ctrl_reg[`PCAP_PATH_A_BIT] ? in_q : PAD_I;
         path_b_reg <= ctrl_reg[`PCAP_PATH_B_BIT] ? in_q : PAD_I;
      end
   end

   assign ARRAY_INPUT_PATH_A_O = path_a_reg;
   assign ARRAY_INPUT_PATH_B_O = path_b_reg;

   // =======================================================================
   // AXI4-Lite write channel
   assign aw_fire = S_AXI_REQ_I.awvalid & awready_reg;
   assign w_fire = S_AXI_REQ_I.wvalid & wready_reg;
   assign wr_do = (aw_have_reg | aw_fire) & (w_have_reg | w_fire);
   assign aw_have_next = (aw_have_reg | aw_fire) & ~wr_do;
   assign w_have_next = (w_have_reg | w_fire) & ~wr_do;
   assign bvalid_next = wr_do | (bvalid_reg & ~S_AXI_REQ_I.bready);
   assign wr_addr = aw_have_reg ? awaddr_reg : S_AXI_REQ_I.awaddr;
   assign wr_data = w_have_reg ? wdata_reg : S_AXI_REQ_I.wdata;
   assign wr_strb = w_have_reg ? wstrb_reg : S_AXI_REQ_I.wstrb;
   assign wr_hit_ctrl = (wr_addr & `PCAP_WORD_MASK) == `PCAP_CTRL_OFS;

   // Byte lanes merge into the control word; reserved bits stay zero
   always_comb begin
      ctrl_next = ctrl_reg;
      for (int i = 0; i < 4; i++) begin
         if (wr_strb[i]) begin
            ctrl_next[8*i +: 8] = wr_data[8*i +: 8];
         end
      end
      ctrl_next = ctrl_next & `PCAP_CTRL_MASK;
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         aw_have_reg <= 1'b0;
         w_have_reg <= 1'b0;
         awaddr_reg <= `PCAP_DATA_ZERO;
         wdata_reg <= `PCAP_DATA_ZERO;
         wstrb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= `PCAP_RESP_OKAY;
      end else begin
         aw_have_reg <= aw_have_next;
         w_have_reg <= w_have_next;
         if (aw_fire) begin
            awaddr_reg <= S_AXI_REQ_I.awaddr;
         end
         if (w_fire) begin
            wdata_reg <= S_AXI_REQ_I.wdata;
            wstrb_reg <= S_AXI_REQ_I.wstrb;
         end
         // Readys fall while a response waits, so one write at a time
         awready_reg <= ~aw_have_next & ~bvalid_next;
         wready_reg <= ~w_have_next & ~bvalid_next;
         bvalid_reg <= bvalid_next;
         if (wr_do) begin
            bresp_reg <= wr_hit_ctrl ? `PCAP_RESP_OKAY : `PCAP_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         ctrl_reg <= `PCAP_CTRL_RESET;
      end else if (wr_do && wr_hit_ctrl) begin
         ctrl_reg <= ctrl_next;
      end
   end

   // =======================================================================
   // AXI4-Lite read channel
   always_comb begin
      status_word = `PCAP_DATA_ZERO;
      status_word[`PCAP_ST_PAD_BIT] = PAD_I;
      status_word[`PCAP_ST_IN_Q_BIT] = in_q;
      status_word[`PCAP_ST_FC_Q_BIT] = fc_q;
      status_word[`PCAP_ST_OUT_Q_BIT] = out_q;
      status_word[`PCAP_ST_CE_IN_BIT] = ce_in;
      status_word[`PCAP_ST_CE_OUT_BIT] = ce_out;
   end

   assign ar_fire = S_AXI_REQ_I.arvalid & arready_reg;
   assign rvalid_next = ar_fire | (rvalid_reg & ~S_AXI_REQ_I.rready);

   always_ff @(posedge SYS_CLK_I) begin
      if (RESET_I) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= `PCAP_DATA_ZERO;
         rresp_reg <= `PCAP_RESP_OKAY;
      end else begin
         arready_reg <= ~rvalid_next;
         rvalid_reg <= rvalid_next;
         if (ar_fire) begin
            if ((S_AXI_REQ_I.araddr & `PCAP_WORD_MASK) == `PCAP_CTRL_OFS) begin
               rdata_reg <= ctrl_reg;
               rresp_reg <= `PCAP_RESP_OKAY;
            end else if ((S_AXI_REQ_I.araddr & `PCAP_WORD_MASK) == `PCAP_STATUS_OFS) begin
               rdata_reg <= status_word;
               rresp_reg <= `PCAP_RESP_OKAY;
            end else begin
               rdata_reg <= `PCAP_DATA_ZERO;
               rresp_reg <= `PCAP_RESP_SLVERR;
            end
         end
      end
   end

   assign S_AXI_RSP_O = {awready_reg, wready_reg, bresp_reg, bvalid_reg,
                         arready_reg, rdata_reg, rresp_reg, rvalid_reg};

   // =======================================================================
   // Checks
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (RESET_I);

   sequence s_in_clean;
      !GLOBAL_SET_RESET_I;
   endsequence

   sequence s_write_answer;
      wr_do ##1 bvalid_reg && !awready_reg && !wready_reg;
   endsequence

   a_flop_capture: assert property (
      s_in_clean and (in_mode == PCAP_MODE_FLOP && in_rise && ce_in) |=> in_q == $past(in_d))
      else $error("Flip-flop missed load on active edge");

   a_flop_no_edge: assert property (
      (s_in_clean and (in_mode == PCAP_MODE_FLOP && !in_rise)) |=> $stable(in_q))
      else $error("Flip-flop changed without an edge");

   a_latch_follow: assert property (
      (s_in_clean and (in_mode == PCAP_MODE_LATCH && in_eff && ce_in)) |=> in_q == $past(in_d))
      else $error("Latch not transparent while open");

   a_latch_hold: assert property (
      (s_in_clean and (in_mode == PCAP_MODE_LATCH && !(IN_CLK_I ^ ctrl_reg[`PCAP_IN_INV_BIT])))
      |=> $stable(in_q))
      else $error("Latch changed while closed");

   a_enable_hold: assert property (
      (s_in_clean and (ctrl_reg[`PCAP_CE_USED_BIT] && !CLK_EN_I && ce_tgt[0]))
      |=> $stable(in_q))
      else $error("Input element changed with enable low");

   a_enable_unused: assert property (
      (s_in_clean and (!ctrl_reg[`PCAP_CE_USED_BIT] && !CLK_EN_I && in_rise
      && in_mode == PCAP_MODE_FLOP)) |=> in_q == $past(in_d))
      else $error("Unused enable blocked a load");

   a_out_steer: assert property (
      (s_in_clean and (ce_tgt == PCAP_CE_IN && out_rise && !CLK_EN_I)) |=> out_q == $past(OUT_D_I))
      else $error("Enable reached output element when steered away");

   a_gsr_init: assert property (
      GLOBAL_SET_RESET_I |=> in_q == $past(init_val) && fc_q == $past(init_val))
      else $error("Global set/reset did not load initial value");

   a_path_select: assert property (
      1'b1 |=> ARRAY_INPUT_PATH_A_O == ($past(ctrl_reg[`PCAP_PATH_A_BIT]) ? $past(in_q)
      : $past(PAD_I)))
      else $error("Path A carries wrong source");

   a_path_b_select: assert property (
      1'b1 |=> ARRAY_INPUT_PATH_B_O == ($past(ctrl_reg[`PCAP_PATH_B_BIT]) ? $past(in_q)
      : $past(PAD_I)))
      else $error("Path B carries wrong source");

   a_fast_pair: assert property (
      (s_in_clean and (ctrl_reg[`PCAP_FC_EN_BIT] && in_rise && ce_in && in_mode == PCAP_MODE_FLOP))
      |=> in_q == $past(fc_q))
      else $error("Combined latch and flip-flop lost data");

   a_write_resp: assert property (
      wr_do |-> s_write_answer)
      else $error("Write response not raised one cycle after write");

   a_read_resp: assert property (
      ar_fire |=> rvalid_reg && !arready_reg)
      else $error("Read data not valid one cycle after address");

endmodule // pcap_top

// >>> tb/pcap_pad_source.sv
// Behavioural model of the external device that drives the package pin.
// Assumes run and data come from the bench, synchronous to the system clock.
`timescale 1ns/1ps
module pcap_pad_source #(
   parameter int HOLD = 3
) (
   input wire logic clk_i,
   input wire logic run_i,
   input wire logic data_i,
   output logic pad_o
);
   int cnt;

   // ======================================================================
   // Pin driver
   initial begin
      pad_o = 1'b0;
      cnt = 0;
   end

   // Levels are held HOLD cycles: a slow device, so the pin never glitches
   always @(posedge clk_i) begin
      if (run_i) begin
         cnt <= (cnt + 1) % HOLD;
         if (cnt == 0) begin
            pad_o <= data_i;
         end
      end
   end
endmodule // pcap_pad_source

// >>> tb/tb_pad_input_capture_register.sv
// Self-checking bench of the pad input capture block.
// Assumes pcap_top with its AXI4-Lite slave and the pad source model.
`timescale 1ns/1ps
module tb_pad_input_capture_register;
   import pcap_pkg::*;
   logic sys_clk, reset, pad, in_clk, out_clk, clk_en, global_set_reset, out_d, run, rnd_bit;
   logic path_a, path_b, out_q, m_pa, m_pb, m_fc, m_in, m_out, prev_i, prev_o;
   logic ieff, oeff, ce_in, ce_out, din;
   pcap_axi_req_t req;
   pcap_axi_rsp_t rsp;
   int fail_count, checks, cycles;
   logic [15:0] lf_cfg, lf_drv;
   logic [1:0] ph;
   logic [9:0] ctrl_m, cfg;
   logic [2:0] e_now, h1, h2, got;
   logic [9:0] cfg_tab [11] = '{10'h003, 10'h007, 10'h00B, 10'h00F, 10'h0A3, 10'h0C7,
      10'h0E3, 10'h10B, 10'h113, 10'h203, 10'h0A7};

   // ======================================================================
   // Clock, design and far side
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   pcap_top uut (.SYS_CLK_I(sys_clk), .RESET_I(reset), .PAD_I(pad), .IN_CLK_I(in_clk),
      .OUT_CLK_I(out_clk), .CLK_EN_I(clk_en), .GLOBAL_SET_RESET_I(global_set_reset), .OUT_D_I(out_d),
      .S_AXI_REQ_I(req), .S_AXI_RSP_O(rsp), .ARRAY_INPUT_PATH_A_O(path_a),
      .ARRAY_INPUT_PATH_B_O(path_b), .OUT_Q_O(out_q));

   pcap_pad_source #(.HOLD(3)) pad_dev (.clk_i(sys_clk), .run_i(run), .data_i(rnd_bit),
      .pad_o(pad));

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic tally_and_finish();
      if (fail_count == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ======================================================================
   // Reference model, cycle based
   assign ieff = in_clk ^ ctrl_m[3];
   assign oeff = out_clk ^ ctrl_m[9];
   assign ce_in = ~ctrl_m[7] | clk_en | ~ctrl_m[5];
   assign ce_out = ~ctrl_m[7] | clk_en | ~ctrl_m[6];
   assign din = ctrl_m[8] ? m_fc : pad;
   assign e_now = {m_pa, m_pb, m_out};
   assign got = {path_a, path_b, out_q};

   always @(posedge sys_clk) begin
      if (reset) begin
         {m_fc, m_in, m_out, m_pa, m_pb, prev_i, prev_o} <= 7'h00;
      end else begin
         if (global_set_reset) begin
            {m_fc, m_in, m_out} <= {3{ctrl_m[4]}};
         end else begin
            if (!oeff) m_fc <= pad;
            if (ce_in && ieff && (ctrl_m[2] || !prev_i)) m_in <= din;
            if (ce_out && oeff && !prev_o) m_out <= out_d;
         end
         prev_i <= ieff;
         prev_o <= oeff;
         m_pa <= ctrl_m[0] ? m_in : pad;
         m_pb <= ctrl_m[1] ? m_in : pad;
      end
      h1 <= e_now;
      h2 <= h1;
   end

   // Latency is the designer's choice, so only settled expectations are compared
   always @(negedge sys_clk) begin
      if (!reset) begin
         for (int i = 0; i < 3; i++) begin
            if (e_now[i] === h1[i] && h1[i] === h2[i]) begin
               check({31'h0, got[i]}, {31'h0, e_now[i]});
            end
         end
      end
   end

   // ======================================================================
   // Random pin stimulus and timeout
   always @(posedge sys_clk) begin
      if (run) begin
         ph <= ph + 2'h1;
         if (ph == 2'h0) begin
            lf_drv <= lfsr_next(lf_drv);
            {in_clk, out_clk, clk_en, out_d, rnd_bit} <= lf_drv[4:0];
         end
      end
      cycles <= cycles + 1;
      if (cycles == 10000) begin
         fail_count++;
         tally_and_finish();
      end
   end

   // ======================================================================
   // AXI4-Lite master
   task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge sys_clk);
      req.awaddr <= a;
      req.awvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hF;
      req.wvalid <= 1'b1;
      req.bready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) begin
            req.wvalid <= 1'b0;
            if (er == 2'h0) ctrl_m <= d[9:0];
         end
      end while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
      check({30'h0, rsp.bresp}, {30'h0, er});
   endtask

   task automatic axi_read(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge sys_clk);
      req.araddr <= a;
      req.arvalid <= 1'b1;
      req.rready <= 1'b1;
      do begin
         @(posedge sys_clk);
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1);
      req.rready <= 1'b0;
      check(rsp.rdata, ed);
      check({30'h0, rsp.rresp}, {30'h0, er});
   endtask

   // ======================================================================
   // Main sequence
   initial begin
      reset = 1'b1;
      {in_clk, out_clk, clk_en, global_set_reset, out_d, run, rnd_bit} = 7'h00;
      req = '0;
      ctrl_m = 10'h060;
      {fail_count, checks, cycles} = {32'h0, 32'h0, 32'h0};
      lf_cfg = 16'h0024;
      lf_drv = 16'h0024;
      ph = 2'h0;
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      repeat (2) @(posedge sys_clk);
      axi_read(32'h0, 32'h0000_0060, 2'h0);
      axi_read(32'h10, 32'h0, 2'h2);
      axi_write(32'h4, 32'hFFFF_FFFF, 2'h2);
      axi_write(32'hC, 32'h1, 2'h2);
      for (int k = 0; k < 36; k++) begin
         cfg = (k < 11) ? cfg_tab[k] : lf_cfg[9:0];
         lf_cfg = lfsr_next(lf_cfg);
         // Global set/reset spans the write so a false edge from an invert bit is masked
         global_set_reset <= 1'b1;
         axi_write(32'h0, {22'h3FFFFF, cfg}, 2'h0);
         axi_read(32'h0, {22'h0, cfg}, 2'h0);
         @(posedge sys_clk);
         global_set_reset <= 1'b0;
         run <= 1'b1;
         repeat (80) @(posedge sys_clk);
         run <= 1'b0;
         repeat (4) @(posedge sys_clk);
         axi_read(32'h4, {26'h0, ce_out, ce_in, m_out, m_fc, m_in, pad}, 2'h0);
      end
      tally_and_finish();
   end
endmodule // tb_pad_input_capture_register
